// file: reload_countdown_timer.sv
/*
 * 16-bit reload countdown timer with APB registers, selectable count
 * clock and start source, plus read-back of the neighbour timer count.
 * Assumes txEnd, rxFirstNibble, timer0Underflow and neighbourUnderflow
 * are one-cycle pulses on ref_clk; lowFreqOscIn is an asynchronous pin.
 */
// Function
// - neighbour timer live count readable as high byte 17h, low 18h
// - stop-on-receive bit set halts timer after first 4 received bits
// - stop-on-receive ignored while either oscillator trimming mode
// - start select 00 no auto start, 01 start at transmission end
// - start select 10/11 trimming without/with underflow, edge start-stop
// - counts down; auto restart reloads at zero and keeps counting, except in start select 10 where it stops
// - without auto restart timer stops on the next count tick after it reaches zero
// - underflow sets the timer's interrupt flag
// - clock select 00 picks 13.56 MHz, 01 picks 212 kHz
// - clock select 10/11 count on timer zero or neighbour underflows
// - every start event loads counter from reload bytes 1Ah and 1Bh
// - reload writes affect only the next start or auto-restart reload, not a running count
`timescale 1ns/10ps
`include "reload_timer_map.svh"

module reload_countdown_timer
	import reload_timer_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire apb_req_s apbReq,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic txEnd,
	input wire logic rxFirstNibble,
	input wire logic lowFreqOscIn,
	input wire logic timer0Underflow,
	input wire logic neighbourUnderflow,
	input wire logic [15:0] neighbourCount,
	output logic underflowPulse,
	output logic underflowIrqFlag,
	output logic timerRunning,
	output logic [15:0] timerCount
);

	function automatic logic [7:0] idxToAddr(input logic [7:0] idx);
		idxToAddr = {idx[5:0], 2'b00};
	endfunction : idxToAddr

	// shared by read mux, write strobes and error answer
	function automatic reg_sel_e decodeAddr(input logic [7:0] addr);
		if (addr == idxToAddr(`TMR_IDX_NCNT_HI)) begin
			decodeAddr = SEL_NCNT_HI;
		end else if (addr == idxToAddr(`TMR_IDX_NCNT_LO)) begin
			decodeAddr = SEL_NCNT_LO;
		end else if (addr == idxToAddr(`TMR_IDX_CTRL)) begin
			decodeAddr = SEL_CTRL;
		end else if (addr == idxToAddr(`TMR_IDX_RELOAD_HI)) begin
			decodeAddr = SEL_RELOAD_HI;
		end else if (addr == idxToAddr(`TMR_IDX_RELOAD_LO)) begin
			decodeAddr = SEL_RELOAD_LO;
		end else if (addr == idxToAddr(`TMR_IDX_STATUS)) begin
			decodeAddr = SEL_STATUS;
		end else if (addr == idxToAddr(`TMR_IDX_COMMAND)) begin
			decodeAddr = SEL_COMMAND;
		end else begin
			decodeAddr = SEL_NONE;
		end
	endfunction : decodeAddr

	ctrl_s ctrl_q;
	logic [7:0] reloadHi_q;
	logic [7:0] reloadLo_q;
	logic [15:0] reloadValue;
	logic [15:0] count_q;
	run_state_e state_q;
	logic flag_q;
	logic underflow_q;
	logic [31:0] prdata_q;
	logic [16:0] carrierAcc_q;
	logic [16:0] slowAcc_q;
	logic [16:0] carrierSum;
	logic [16:0] slowSum;
	logic carrierTick;
	logic slowTick;
	logic lowFreqOscRise;
	logic tick;
	logic running;
	logic lfoMode;
	logic swStart;
	logic swStop;
	logic startEv;
	logic stopEv;
	logic atZero;
	logic underflowEv;
	logic apbSetup;
	logic apbAccess;
	logic apbWrite;
	reg_sel_e setupSel;
	reg_sel_e accessSel;

	pin_sync #(
		.WIDTH(1)
	) u_osc_sync (
		.ref_clk(ref_clk),
		.reset(reset),
		.pinIn(lowFreqOscIn),
		.pinLevel(),
		.pinRise(lowFreqOscRise)
	);

	// fractional dividers keep the long-run rate exact at the cost of
	// a one-cycle jitter on each tick
	assign carrierSum = carrierAcc_q + `TMR_CARRIER_KHZ;
	assign slowSum = slowAcc_q + `TMR_SLOW_KHZ;
	assign carrierTick = carrierSum >= `TMR_REF_CLK_KHZ;
	assign slowTick = slowSum >= `TMR_REF_CLK_KHZ;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			carrierAcc_q <= 17'h00000;
			slowAcc_q <= 17'h00000;
		end else begin
			carrierAcc_q <= carrierTick ?
				17'(carrierSum - `TMR_REF_CLK_KHZ) : carrierSum;
			slowAcc_q <= slowTick ?
				17'(slowSum - `TMR_REF_CLK_KHZ) : slowSum;
		end
	end

	always_comb begin
		case (ctrl_q.clockSelect)
			CLK_CARRIER: tick = carrierTick;
			CLK_212K: tick = slowTick;
			CLK_TIMER0_UF: tick = timer0Underflow;
			CLK_NEIGHBOUR_UF: tick = neighbourUnderflow;
			default: tick = 1'b0;
		endcase
	end

	// bus decode; reads are latched in the setup cycle so prdata is a flop
	assign apbSetup = apbReq.psel & ~apbReq.penable;
	assign apbAccess = apbReq.psel & apbReq.penable;
	assign setupSel = decodeAddr(apbReq.paddr);
	assign accessSel = setupSel;
	assign apbWrite = apbAccess & apbReq.pwrite & (accessSel != SEL_NONE);
	assign pready = 1'b1;
	assign pslverr = apbAccess & (accessSel == SEL_NONE);
	assign prdata = prdata_q;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			prdata_q <= 32'h00000000;
		end else if (apbSetup) begin
			prdata_q <= 32'h00000000;
			case (setupSel)
				SEL_NCNT_HI: prdata_q[7:0] <= neighbourCount[15:8];
				SEL_NCNT_LO: prdata_q[7:0] <= neighbourCount[7:0];
				SEL_CTRL: prdata_q[7:0] <= ctrl_q;
				SEL_RELOAD_HI: prdata_q[7:0] <= reloadHi_q;
				SEL_RELOAD_LO: prdata_q[7:0] <= reloadLo_q;
				SEL_STATUS: begin
					prdata_q[`TMR_STATUS_FLAG_BIT] <= flag_q;
					prdata_q[`TMR_STATUS_RUN_BIT] <= running;
				end
				default: prdata_q <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ctrl_q <= ctrl_s'(`TMR_CTRL_RESET);
		end else if (apbWrite && accessSel == SEL_CTRL) begin
			ctrl_q <= ctrl_s'(apbReq.pwdata[7:0] & `TMR_CTRL_WMASK);
		end
	end

	// only the stored bytes change here; the counter sees them at a start or an auto-restart reload
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			reloadHi_q <= 8'(`TMR_RELOAD_RESET >> 8);
			reloadLo_q <= 8'(`TMR_RELOAD_RESET);
		end else if (apbWrite) begin
			if (accessSel == SEL_RELOAD_HI) begin
				reloadHi_q <= apbReq.pwdata[7:0];
			end
			if (accessSel == SEL_RELOAD_LO) begin
				reloadLo_q <= apbReq.pwdata[7:0];
			end
		end
	end
	assign reloadValue = {reloadHi_q, reloadLo_q};

	assign swStart = apbWrite & (accessSel == SEL_COMMAND) &
		apbReq.pwdata[`TMR_CMD_START_BIT];
	assign swStop = apbWrite & (accessSel == SEL_COMMAND) &
		apbReq.pwdata[`TMR_CMD_STOP_BIT];
	assign running = state_q == TIMER_COUNTING;
	assign lfoMode = ctrl_q.startSelect == START_LFO_TRIM ||
		ctrl_q.startSelect == START_LFO_TRIM_UF;

	// one oscillator edge starts an idle timer and stops a running one
	assign startEv = swStart |
		(txEnd & ctrl_q.startSelect == START_TX_END) |
		(lowFreqOscRise & lfoMode & ~running);
	assign stopEv = swStop |
		(rxFirstNibble & ctrl_q.stopOnReceive & ~lfoMode) |
		(lowFreqOscRise & lfoMode & running);
	assign atZero = count_q == 16'h0000;
	assign underflowEv = running & tick & atZero & ~startEv & ~stopEv &
		(ctrl_q.startSelect != START_LFO_TRIM);

	// start wins over a stop in the same cycle
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q <= TIMER_IDLE;
			count_q <= `TMR_COUNT_RESET;
		end else if (startEv) begin
			state_q <= TIMER_COUNTING;
			count_q <= reloadValue;
		end else begin
			case (state_q)
				TIMER_IDLE: state_q <= TIMER_IDLE;
				TIMER_COUNTING: begin
					if (stopEv) begin
						state_q <= TIMER_IDLE;
					end else if (tick && atZero) begin
						if (underflowEv && ctrl_q.autoRestart) begin
							count_q <= reloadValue;
						end else begin
							state_q <= TIMER_IDLE;
						end
					end else if (tick) begin
						count_q <= 16'(count_q - 16'h0001);
					end
				end
				default: state_q <= TIMER_IDLE;
			endcase
		end
	end

	// set beats a write-one-to-clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			flag_q <= 1'b0;
		end else if (underflowEv) begin
			flag_q <= 1'b1;
		end else if (apbWrite && accessSel == SEL_STATUS &&
			apbReq.pwdata[`TMR_STATUS_FLAG_BIT]) begin
			flag_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			underflow_q <= 1'b0;
		end else begin
			underflow_q <= underflowEv;
		end
	end

	assign underflowPulse = underflow_q;
	assign underflowIrqFlag = flag_q;
	assign timerRunning = running;
	assign timerCount = count_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	AST_NCNT_HI_READ: assert property (
		apbAccess && !apbReq.pwrite && accessSel == SEL_NCNT_HI |->
		prdata == {24'h000000, $past(neighbourCount[15:8])})
		else $error("neighbour high byte read wrong");
	AST_NCNT_LO_READ: assert property (
		apbAccess && !apbReq.pwrite && accessSel == SEL_NCNT_LO |->
		prdata == {24'h000000, $past(neighbourCount[7:0])})
		else $error("neighbour low byte read wrong");
	AST_STOP_ON_RX: assert property (
		running && rxFirstNibble && ctrl_q.stopOnReceive && !lfoMode &&
		!startEv |=> !running)
		else $error("timer kept running after first nibble");
	AST_RX_IGNORED_LFO: assert property (
		running && rxFirstNibble && lfoMode && !lowFreqOscRise &&
		!swStop && !(tick && atZero) |=> running)
		else $error("trimming mode stopped by reception");
	AST_TX_END_START: assert property (
		txEnd && ctrl_q.startSelect == START_TX_END |=>
		running && count_q == $past(reloadValue))
		else $error("no start at transmission end");
	AST_NO_AUTO_START: assert property (
		!running && ctrl_q.startSelect == START_NONE && !swStart |=>
		!running)
		else $error("timer started with no start source");
	AST_LFO_EDGE: assert property (
		lfoMode && lowFreqOscRise && !swStart |=>
		running != $past(running))
		else $error("oscillator edge did not toggle timer");
	AST_NO_UF_TRIM: assert property (
		underflowPulse |-> $past(ctrl_q.startSelect) != START_LFO_TRIM)
		else $error("underflow in trimming without underflow");
	AST_AUTO_RELOAD: assert property (
		underflowEv && ctrl_q.autoRestart |=>
		running && count_q == $past(reloadValue))
		else $error("auto restart did not reload");
	AST_STOP_AT_ZERO: assert property (
		running && tick && atZero && !ctrl_q.autoRestart && !startEv |=>
		!running)
		else $error("timer did not stop at zero");
	AST_FLAG_SET: assert property (
		underflowEv |=> underflowIrqFlag && underflowPulse)
		else $error("underflow did not set flag");
	AST_CARRIER_RATE: assert property (
		carrierTick |=> !carrierTick ##[0:7] carrierTick)
		else $error("carrier tick rate wrong");
	AST_CHAIN_STEP: assert property (
		running && ctrl_q.clockSelect == CLK_TIMER0_UF &&
		timer0Underflow && !atZero && !startEv && !stopEv |=>
		count_q == 16'($past(count_q) - 16'h0001))
		else $error("chained count did not step");
	AST_RELOAD_NO_EFFECT: assert property (
		running && apbWrite && !tick && !startEv && !stopEv |=>
		count_q == $past(count_q))
		else $error("register write disturbed running count");
	AST_RSVD_ZERO: assert property (
		apbAccess && !apbReq.pwrite && accessSel == SEL_CTRL |->
		prdata[6] == 1'b0 && prdata[2] == 1'b0)
		else $error("reserved control bits not zero");
	AST_UF_PULSE: assert property (
		underflowPulse |-> $past(running) && $past(count_q) == 16'h0000)
		else $error("underflow pulse without zero count");
	AST_SW_START: assert property (
		swStart |=> running && count_q == $past(reloadValue))
		else $error("command start did not load reload");

	COV_AUTO_RESTART: cover property (underflowEv && ctrl_q.autoRestart);
	COV_STOP_RX: cover property (running && stopEv && rxFirstNibble);
	COV_LFO_START: cover property (lfoMode && lowFreqOscRise && !running);
	COV_BUS_ERROR: cover property (pslverr);
	COV_SW_START: cover property (swStart && !running);

endmodule : reload_countdown_timer

// file: reload_timer_map.svh
/*
 * Register indices, field positions, reset values and rate constants of
 * the reload countdown timer.
 * Assumes it is included by its bare name before any user of the macros.
 */
`ifndef RELOAD_TIMER_MAP_SVH
`define RELOAD_TIMER_MAP_SVH

// register indices; the byte address is four times the index
`define TMR_IDX_NCNT_HI 8'h17
`define TMR_IDX_NCNT_LO 8'h18
`define TMR_IDX_CTRL 8'h19
`define TMR_IDX_RELOAD_HI 8'h1A
`define TMR_IDX_RELOAD_LO 8'h1B
`define TMR_IDX_STATUS 8'h3E
`define TMR_IDX_COMMAND 8'h3F

// control field positions
`define TMR_CTRL_STOPRX_BIT 7
`define TMR_CTRL_START_LSB 4
`define TMR_CTRL_AUTO_BIT 3
`define TMR_CTRL_CLK_LSB 0
// writable control bits; bits 6 and 2 are reserved
`define TMR_CTRL_WMASK 8'hBB

// status and command bits
`define TMR_STATUS_FLAG_BIT 0
`define TMR_STATUS_RUN_BIT 1
`define TMR_CMD_START_BIT 0
`define TMR_CMD_STOP_BIT 1

// reset values
`define TMR_CTRL_RESET 8'h00
`define TMR_RELOAD_RESET 16'h0000
`define TMR_COUNT_RESET 16'h0000

// rates in kHz; count clocks come from fractional accumulators
`define TMR_REF_CLK_KHZ 17'h186A0
`define TMR_CARRIER_KHZ 17'h034F8
`define TMR_SLOW_KHZ 17'h000D4

`endif

// file: reload_timer_pkg.sv
/*
 * Types of the reload countdown timer: bus request, control layout and
 * mode enumerations.
 * Assumes reload_timer_map.svh is on the include path.
 */
`include "reload_timer_map.svh"

package reload_timer_pkg;

	typedef enum logic [1:0] {
		START_NONE,
		START_TX_END,
		START_LFO_TRIM,
		START_LFO_TRIM_UF
	} start_sel_e;

	typedef enum logic [1:0] {
		CLK_CARRIER,
		CLK_212K,
		CLK_TIMER0_UF,
		CLK_NEIGHBOUR_UF
	} clock_sel_e;

	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_NCNT_HI,
		SEL_NCNT_LO,
		SEL_CTRL,
		SEL_RELOAD_HI,
		SEL_RELOAD_LO,
		SEL_STATUS,
		SEL_COMMAND
	} reg_sel_e;

	typedef enum logic {
		TIMER_IDLE,
		TIMER_COUNTING
	} run_state_e;

	typedef struct packed {
		logic stopOnReceive;
		logic reserved6;
		start_sel_e startSelect;
		logic autoRestart;
		logic reserved2;
		clock_sel_e clockSelect;
	} ctrl_s;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

endpackage : reload_timer_pkg

// file: pin_sync.sv
/*
 * Two-flop synchroniser with rising-edge detect for pins.
 * Assumes inputs are asynchronous to ref_clk; outputs are on ref_clk.
 */
`timescale 1ns/10ps

module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinLevel,
	output logic [WIDTH-1:0] pinRise
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] last_q;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge ref_clk) begin
				if (reset) begin
					meta_q[i] <= 1'b0;
					sync_q[i] <= 1'b0;
					last_q[i] <= 1'b0;
				end else begin
					meta_q[i] <= pinIn[i];
					sync_q[i] <= meta_q[i];
					last_q[i] <= sync_q[i];
				end
			end
			assign pinRise[i] = sync_q[i] & ~last_q[i];
		end
	endgenerate

	assign pinLevel = sync_q;

endmodule : pin_sync

// file: reload_countdown_timer_tb.sv
/*
 * Self-checking testbench of the reload countdown timer: APB register
 * access, start sources, count clocks, reload, underflow and stop paths.
 * Assumes reload_timer_pkg and reload_timer_map.svh are compiled first.
 */
`timescale 1ns/10ps
`include "reload_timer_map.svh"

module reload_countdown_timer_tb
	import reload_timer_pkg::*;
;
	localparam logic [7:0] A_NHI = 8'(`TMR_IDX_NCNT_HI << 2);
	localparam logic [7:0] A_NLO = 8'(`TMR_IDX_NCNT_LO << 2);
	localparam logic [7:0] A_CTRL = 8'(`TMR_IDX_CTRL << 2);
	localparam logic [7:0] A_RHI = 8'(`TMR_IDX_RELOAD_HI << 2);
	localparam logic [7:0] A_RLO = 8'(`TMR_IDX_RELOAD_LO << 2);
	localparam logic [7:0] A_STAT = 8'(`TMR_IDX_STATUS << 2);
	localparam logic [7:0] A_CMD = 8'(`TMR_IDX_COMMAND << 2);
	localparam logic [3:0] TX = 4'h8, RX = 4'h4, T0 = 4'h2, NB = 4'h1;
	logic ref_clk, reset, lowFreqOscIn;
	logic [3:0] ev;
	wire txEnd, rxFirstNibble, timer0Underflow, neighbourUnderflow;
	logic [15:0] neighbourCount, timerCount, rv;
	apb_req_s apbReq;
	logic [31:0] prdata;
	logic pready, pslverr, underflowPulse, underflowIrqFlag, timerRunning;
	logic [32:0] expQ[$];
	logic [32:0] e;
	int num_errors = 0, checked = 0, ufCount = 0, i, n, u0;

	assign {txEnd, rxFirstNibble, timer0Underflow, neighbourUnderflow} = ev;

	reload_countdown_timer u_reload_countdown_timer (
		.ref_clk(ref_clk), .reset(reset), .apbReq(apbReq), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .txEnd(txEnd),
		.rxFirstNibble(rxFirstNibble), .lowFreqOscIn(lowFreqOscIn),
		.timer0Underflow(timer0Underflow),
		.neighbourUnderflow(neighbourUnderflow),
		.neighbourCount(neighbourCount), .underflowPulse(underflowPulse),
		.underflowIrqFlag(underflowIrqFlag), .timerRunning(timerRunning),
		.timerCount(timerCount));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic fail(input string m);
		num_errors++;
		$display("CHECK FAILED at %0t: %s", $time, m);
	endtask : fail

	task automatic cmp(input logic [31:0] got, exp, input string m);
		checked++;
		if (got !== exp) fail(m);
	endtask : cmp

	task automatic wrap_up;
		$display("comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	// the driver notes the expected answer; the monitor below judges it
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, exp, input logic err);
		expQ.push_back({err, exp});
		@(posedge ref_clk);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge ref_clk);
		apbReq.penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		apbReq <= '0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 1'b0);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, exp, 1'b0);
	endtask : rd

	task automatic pulse(input logic [3:0] m);
		@(posedge ref_clk);
		ev <= m;
		@(posedge ref_clk);
		ev <= 4'h0;
		#1;
	endtask : pulse

	task automatic ticks(input int k);
		for (int j = 0; j < k; j++) pulse(T0);
	endtask : ticks

	// pin edge is seen a few edges late because of the synchroniser
	task automatic osc;
		@(posedge ref_clk);
		lowFreqOscIn <= 1'b1;
		repeat (5) @(posedge ref_clk);
		lowFreqOscIn <= 1'b0;
		repeat (4) @(posedge ref_clk);
		#1;
	endtask : osc

	task automatic waitUf(input int lim, output int k);
		int base;
		base = ufCount;
		for (k = 0; k < lim && ufCount == base; k++) begin
			@(posedge ref_clk);
			#1;
		end
	endtask : waitUf

	always @(posedge ref_clk) begin
		if (underflowPulse === 1'b1) ufCount++;
		if (apbReq.psel && apbReq.penable && pready === 1'b1) begin
			if (expQ.size() == 0) fail("transfer with no expectation");
			else begin
				e = expQ.pop_front();
				checked++;
				if (pslverr !== e[32]) fail("slave error flag wrong");
				else if (!apbReq.pwrite && prdata !== e[31:0]) fail("read data wrong");
			end
		end
	end

	initial begin
		repeat (30000) @(posedge ref_clk);
		fail("timeout");
		wrap_up();
	end

	initial begin
		ev = 4'h0;
		apbReq = '0;
		lowFreqOscIn = 1'b0;
		neighbourCount = 16'h0000;
		reset = 1'b1;
		void'($urandom(32'h45B0));
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		rd(A_CTRL, 32'h0);
		rd(A_RHI, 32'h0);
		rd(A_RLO, 32'h0);
		rd(A_STAT, 32'h0);
		cmp(timerCount, 32'h0, "count after reset");
		wr(A_CTRL, 32'hFF);
		rd(A_CTRL, 32'hBB);
		rv = 16'($urandom);
		wr(A_CTRL, {24'h0, rv[7:0]});
		rd(A_CTRL, {24'h0, rv[7:0] & 8'hBB});
		apb(1'b0, 8'h00, 32'h0, 32'h0, 1'b1);
		apb(1'b1, 8'h65, 32'hFF, 32'h0, 1'b1);
		rd(A_CTRL, {24'h0, rv[7:0] & 8'hBB});
		// no reception runs here, so the live count is safe to read
		for (i = 0; i < 3; i++) begin
			rv = 16'($urandom);
			neighbourCount <= rv;
			rd(A_NHI, {24'h0, rv[15:8]});
			rd(A_NLO, {24'h0, rv[7:0]});
		end
		$display("test registers done");
		rv = 16'($urandom_range(8, 200));
		wr(A_RHI, {24'h0, rv[15:8]});
		wr(A_RLO, {24'h0, rv[7:0]});
		wr(A_CTRL, 32'h02);
		pulse(TX);
		cmp(timerRunning, 32'h0, "start without auto start");
		wr(A_CTRL, 32'h12);
		pulse(TX);
		cmp(timerRunning, 32'h1, "start at end of transmission");
		cmp(timerCount, rv, "loaded from reload");
		wr(A_RHI, 32'h0);
		wr(A_RLO, 32'h3);
		pulse(T0);
		pulse(NB);
		pulse(T0);
		cmp(timerCount, rv - 16'h2, "count after writes");
		u0 = ufCount;
		ticks(rv - 2);
		cmp(timerCount, 32'h0, "count at zero");
		cmp(timerRunning, 32'h1, "still running at zero");
		pulse(T0);
		repeat (3) @(posedge ref_clk);
		#1;
		cmp(ufCount - u0, 32'h1, "one underflow pulse");
		cmp(underflowIrqFlag, 32'h1, "flag set");
		cmp(timerRunning, 32'h0, "stops without restart");
		rd(A_STAT, 32'h1);
		wr(A_STAT, 32'h1);
		rd(A_STAT, 32'h0);
		$display("test single shot done");
		wr(A_CTRL, 32'h1A);
		pulse(TX);
		cmp(timerCount, 32'h3, "new reload at next start");
		u0 = ufCount;
		ticks(4);
		repeat (3) @(posedge ref_clk);
		#1;
		cmp(ufCount - u0, 32'h1, "underflow with restart");
		cmp(timerRunning, 32'h1, "keeps running");
		cmp(timerCount, 32'h3, "reloaded after zero");
		wr(A_CTRL, 32'h1B);
		pulse(NB);
		pulse(RX);
		pulse(T0);
		cmp(timerCount, 32'h2, "neighbour underflow counts");
		cmp(timerRunning, 32'h1, "receive ignored when bit clear");
		wr(A_CTRL, 32'h9B);
		pulse(RX);
		cmp(timerRunning, 32'h0, "stop on receive");
		$display("test restart done");
		// mode 00 runs only on the software command
		wr(A_CTRL, 32'h02);
		wr(A_CMD, 32'h1);
		#1;
		cmp(timerRunning, 32'h1, "command start");
		cmp(timerCount, 32'h3, "command start loads reload");
		wr(A_CMD, 32'h2);
		#1;
		cmp(timerRunning, 32'h0, "command stop");
		rd(A_CMD, 32'h0);
		wr(A_STAT, 32'h1);
		wr(A_CTRL, 32'hA2);
		osc();
		cmp(timerRunning, 32'h1, "oscillator edge starts");
		pulse(RX);
		cmp(timerRunning, 32'h1, "receive ignored in trim mode");
		osc();
		cmp(timerRunning, 32'h0, "oscillator edge stops");
		osc();
		cmp(timerCount, 32'h3, "trim start loads reload");
		u0 = ufCount;
		ticks(4);
		repeat (3) @(posedge ref_clk);
		#1;
		cmp(ufCount - u0, 32'h0, "no underflow in mode 10");
		cmp(underflowIrqFlag, 32'h0, "no flag in mode 10");
		cmp(timerRunning, 32'h0, "mode 10 stops at zero");
		wr(A_CTRL, 32'hB2);
		osc();
		pulse(RX);
		ticks(4);
		repeat (3) @(posedge ref_clk);
		#1;
		cmp(ufCount - u0, 32'h1, "underflow in mode 11");
		cmp(underflowIrqFlag, 32'h1, "flag in mode 11");
		$display("test trimming done");
		wr(A_RLO, 32'h1);
		wr(A_CTRL, 32'h10);
		pulse(TX);
		waitUf(60, n);
		cmp(n < 40, 32'h1, "carrier clock too slow");
		wr(A_CTRL, 32'h11);
		pulse(TX);
		waitUf(1200, n);
		cmp(n > 400 && n < 1100, 32'h1, "slow clock rate wrong");
		$display("test count clocks done");
		for (i = 0; i < 10 && expQ.size() != 0; i++) @(posedge ref_clk);
		if (expQ.size() != 0) fail("answers missing");
		wrap_up();
	end
endmodule : reload_countdown_timer_tb
